// ---- verilog/mrpc_params.svh ----
// constants for module reset and power control
`ifndef MRPC_PARAMS_SVH
`define MRPC_PARAMS_SVH

`define MRPC_SYS_CLK_HZ       125000000
`define MRPC_LF_CLK_HZ        32768
`define MRPC_PIN_RST_MIN_US   1500
`define MRPC_PIN_RST_MAX_US   4000
`define MRPC_PIN_RST_TICKS    ((`MRPC_PIN_RST_MIN_US * `MRPC_LF_CLK_HZ + 999999) / 1000000 + 1)
`define MRPC_PIN_RST_MIN_CYC  (`MRPC_PIN_RST_MIN_US * (`MRPC_SYS_CLK_HZ / 1000000))
`define MRPC_PIN_RST_MAX_CYC  (`MRPC_PIN_RST_MAX_US * (`MRPC_SYS_CLK_HZ / 1000000))
`define MRPC_SOFT_RST_CYC     16
`define MRPC_MV_W             12
`define MRPC_POR_ASSERT_MV    12'h41a
`define MRPC_POR_RELEASE_MV   12'h44c
`define MRPC_NUM_REG          4
`define MRPC_NUM_PIO          6
`define MRPC_NUM_DPAD         8
`define MRPC_XTAL_W           16
`define MRPC_CAUSE_W          4
`define MRPC_CAUSE_POR        0
`define MRPC_CAUSE_PIN        1
`define MRPC_CAUSE_WDOG       2
`define MRPC_CAUSE_HOST       3

`endif

// ---- verilog/mrpc_pkg.sv ----
// types for module reset and power control
package mrpc_pkg;

    typedef enum logic [4:0] {
        ST_POR  = 5'h01,
        ST_PIN  = 5'h02,
        ST_SOFT = 5'h04,
        ST_BOOT = 5'h08,
        ST_RUN  = 5'h10
    } mrpc_state_t;

    typedef enum logic [2:0] {
        HM_SD1 = 3'h1,
        HM_SD4 = 3'h2,
        HM_SPI = 3'h4
    } mrpc_host_mode_t;

endpackage : mrpc_pkg

// ---- verilog/mrpc_reset_filter.sv ----
// reset pin synchroniser and low-frequency-clock glitch filter
`timescale 1ns/1ns
`include "mrpc_params.svh"

module mrpc_reset_filter #(
    parameter int TICKS = `MRPC_PIN_RST_TICKS
) (
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic lf_clk_in,
    input  wire logic reset_pin_b_in,
    output logic      pin_low_s,
    output logic      pin_filt
);
    localparam int CW = $clog2(TICKS + 1);
    localparam logic [CW-1:0] TICKS_W = CW'(TICKS);

    logic          pin_s1_reg;
    logic          pin_s2_reg;
    logic          lf_s1_reg;
    logic          lf_s2_reg;
    logic          lf_d_reg;
    logic [CW-1:0] cnt_reg;
    logic          filt_reg;
    logic          lf_tick;

    // both are foreign to sys_clk; only the second stage and its delayed copy lf_d_reg are read
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            lf_s1_reg  <= 1'b0;
            lf_s2_reg  <= 1'b0;
            lf_d_reg   <= 1'b0;
        end else begin
            pin_s1_reg <= reset_pin_b_in;
            pin_s2_reg <= pin_s1_reg;
            lf_s1_reg  <= lf_clk_in;
            lf_s2_reg  <= lf_s1_reg;
            lf_d_reg   <= lf_s2_reg;
        end
    end

    assign lf_tick = lf_s2_reg & ~lf_d_reg;

    // one extra tick covers the partial first period
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= '0;
        end else if (pin_s2_reg) begin
            cnt_reg <= '0;
        end else if (lf_tick && cnt_reg != TICKS_W) begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            filt_reg <= 1'b0;
        end else begin
            filt_reg <= ~pin_s2_reg && cnt_reg == TICKS_W;
        end
    end

    assign pin_low_s = ~pin_s2_reg;
    assign pin_filt  = filt_reg;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_filt_restart: assert property (pin_s2_reg |=> cnt_reg == '0 && !filt_reg)
        else $error("filter count not restarted by high pin");
    a_filt_complete: assert property ($rose(filt_reg) |-> $past(cnt_reg) == TICKS_W)
        else $error("filtered reset before count complete");

endmodule : mrpc_reset_filter

// ---- verilog/mrpc_top.sv ----
// reset source gathering, core power control and pad reset states
`timescale 1ns/1ns
`include "mrpc_params.svh"

// Functional notes
// - reset requests come from pin, power-on monitor, watchdog and host interface
// - reset pin is active low, filtered by low-frequency oscillator
// - internal pin reset follows 1.5 ms to 4.0 ms after pin low
// - power-on reset below 1.05 V core, released above 1.10 V
// - any reset tristates pads with pull-downs; reset and debug select pulled up
// - host interface reset only by pin reset or power-on reset
// - cutting regulator supply or pulsing regulator enable low gives power-on reset
// - boot clocks internal after reset until software sets crystal frequency
// - holding reset pin low never enters a low-power state
// - regulator enable active high; high enables core regulators
// - firmware may switch off some core regulators regardless of enable pin
// - core power loss stops processors; return causes power-on reset
// - regulator enable low leaves always-on coexistence and function 0 alive
// - programmable lines leave reset as inputs with weak pull-downs
// - host mode holds until pin or power-on reset restores one-bit mode
module mrpc_top
    import mrpc_pkg::*;
#(
    parameter int NUM_PIO     = `MRPC_NUM_PIO,
    parameter int NUM_DPAD    = `MRPC_NUM_DPAD,
    parameter int NUM_REG     = `MRPC_NUM_REG,
    parameter int PIN_TICKS   = `MRPC_PIN_RST_TICKS,
    parameter int PIN_MIN_CYC = `MRPC_PIN_RST_MIN_CYC,
    parameter int PIN_MAX_CYC = `MRPC_PIN_RST_MAX_CYC,
    parameter int SOFT_CYC    = `MRPC_SOFT_RST_CYC
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst_b,
    input  wire logic                      reset_pin_b_in,
    input  wire logic                      lf_clk_in,
    input  wire logic                      regulator_enable_pin,
    input  wire logic                      core_regulator_input_supply_ok,
    input  wire logic [`MRPC_MV_W-1:0]     core_supply_mv,
    input  wire logic                      wdog_rst_req,
    input  wire logic                      host_rst_req,
    input  wire logic [NUM_REG-1:0]        fw_reg_off,
    input  wire logic                      fw_low_power_req,
    input  wire logic                      fw_xtal_cfg_wr,
    input  wire logic [`MRPC_XTAL_W-1:0]   fw_xtal_freq,
    input  wire logic                      host_mode_wr,
    input  wire logic [2:0]                host_mode_sel,
    input  wire logic                      pio_cfg_wr,
    input  wire logic [NUM_PIO-1:0]        pio_cfg_dir,
    input  wire logic [NUM_PIO-1:0]        pio_cfg_out,
    input  wire logic [NUM_PIO-1:0]        pio_cfg_pd,
    input  wire logic [NUM_PIO-1:0]        pio_cfg_pu,
    input  wire logic [NUM_PIO-1:0]        programmable_io_line_in,
    input  wire logic [NUM_DPAD-1:0]       dpad_oe_b_req,
    input  wire logic [NUM_DPAD-1:0]       dpad_pd_req,
    output logic                           core_rst_b,
    output logic                           host_if_rst_b,
    output logic                           por_active,
    output logic [NUM_REG-1:0]             core_reg_en,
    output logic                           low_power_en,
    output logic                           boot_clk_int,
    output logic [`MRPC_XTAL_W-1:0]        xtal_freq,
    output logic [2:0]                     host_mode,
    output logic [`MRPC_CAUSE_W-1:0]       reset_cause,
    output logic [NUM_PIO-1:0]             programmable_io_line_out,
    output logic [NUM_PIO-1:0]             programmable_io_line_oe_b,
    output logic [NUM_PIO-1:0]             programmable_io_line_pull_dn,
    output logic [NUM_PIO-1:0]             programmable_io_line_pull_up,
    output logic [NUM_PIO-1:0]             programmable_io_line_val,
    output logic [NUM_DPAD-1:0]            dpad_oe_b,
    output logic [NUM_DPAD-1:0]            dpad_pull_dn,
    output logic                           reset_pad_pull_up,
    output logic                           dbg_cs_pull_up,
    output logic                           aon_domain_en
);
    localparam int SCW = $clog2(SOFT_CYC + 1);
    localparam int PCW = $clog2(PIN_MAX_CYC + 1);
    localparam logic [SCW-1:0] SOFT_LOAD = SCW'(SOFT_CYC - 1);
    localparam logic [PCW-1:0] PIN_MIN_W = PCW'(PIN_MIN_CYC);
    localparam logic [PCW-1:0] PIN_MAX_W = PCW'(PIN_MAX_CYC);

    mrpc_state_t                state_reg;
    mrpc_state_t                state_next;
    logic                       regulator_enable_pin_s1_reg;
    logic                       regulator_enable_pin_s2_reg;
    logic                       vin_s1_reg;
    logic                       vin_s2_reg;
    logic                       core_pwr_s;
    logic                       por_reg;
    logic                       pin_low_s;
    logic                       pin_filt;
    logic                       soft_req;
    logic                       in_rst_next;
    logic                       hif_rst_next;
    logic [SCW-1:0]             soft_cnt_reg;
    logic [PCW-1:0]             pin_low_cyc_reg;
    logic                       core_rst_b_reg;
    logic                       host_if_rst_b_reg;
    logic [NUM_REG-1:0]         core_reg_en_reg;
    logic                       low_power_en_reg;
    logic                       boot_clk_int_reg;
    logic [`MRPC_XTAL_W-1:0]    xtal_freq_reg;
    logic [2:0]                 host_mode_reg;
    logic [`MRPC_CAUSE_W-1:0]   cause_reg;
    logic [`MRPC_CAUSE_W-1:0]   cause_next;
    logic [NUM_DPAD-1:0]        dpad_oe_b_reg;
    logic [NUM_DPAD-1:0]        dpad_pull_dn_reg;
    logic                       pull_up_reg;

    // board-level pins: two flops before any use
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            regulator_enable_pin_s1_reg <= 1'b0;
            regulator_enable_pin_s2_reg <= 1'b0;
            vin_s1_reg   <= 1'b0;
            vin_s2_reg   <= 1'b0;
        end else begin
            regulator_enable_pin_s1_reg <= regulator_enable_pin;
            regulator_enable_pin_s2_reg <= regulator_enable_pin_s1_reg;
            vin_s1_reg   <= core_regulator_input_supply_ok;
            vin_s2_reg   <= vin_s1_reg;
        end
    end

    assign core_pwr_s = regulator_enable_pin_s2_reg & vin_s2_reg;

    // hysteresis keeps a noisy supply from chattering the core reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            por_reg <= 1'b1;
        end else if (!core_pwr_s || core_supply_mv < `MRPC_POR_ASSERT_MV) begin
            por_reg <= 1'b1;
        end else if (core_supply_mv > `MRPC_POR_RELEASE_MV) begin
            por_reg <= 1'b0;
        end
    end

    mrpc_reset_filter #(
        .TICKS          (PIN_TICKS)
    ) u_filter (
        .sys_clk        (sys_clk),
        .rst_b          (rst_b),
        .lf_clk_in      (lf_clk_in),
        .reset_pin_b_in (reset_pin_b_in),
        .pin_low_s      (pin_low_s),
        .pin_filt       (pin_filt)
    );

    // soft requests are meaningless while pin reset holds the core or it is unpowered
    assign soft_req = (wdog_rst_req | host_rst_req) &
                      (state_reg inside {ST_SOFT, ST_BOOT, ST_RUN});

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_POR:  if (!por_reg) state_next = ST_BOOT;
            ST_PIN:  if (!pin_filt) state_next = ST_BOOT;
            ST_SOFT: if (soft_cnt_reg == '0) state_next = ST_BOOT;
            ST_BOOT: if (fw_xtal_cfg_wr) state_next = ST_RUN;
            ST_RUN:  state_next = ST_RUN;
        endcase
        if (soft_req) state_next = ST_SOFT;
        if (pin_filt) state_next = ST_PIN;
        if (por_reg) state_next = ST_POR;
    end

    assign in_rst_next  = state_next inside {ST_POR, ST_PIN, ST_SOFT};
    assign hif_rst_next = state_next inside {ST_POR, ST_PIN};

    always_comb begin
        cause_next = '0;
        cause_next[`MRPC_CAUSE_POR]  = state_next == ST_POR;
        cause_next[`MRPC_CAUSE_PIN]  = state_next == ST_PIN;
        cause_next[`MRPC_CAUSE_WDOG] = state_next == ST_SOFT && wdog_rst_req;
        cause_next[`MRPC_CAUSE_HOST] = state_next == ST_SOFT && host_rst_req;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_POR;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            soft_cnt_reg <= '0;
        end else if (soft_req) begin
            soft_cnt_reg <= SOFT_LOAD;
        end else if (state_reg == ST_SOFT && soft_cnt_reg != '0) begin
            soft_cnt_reg <= soft_cnt_reg - SCW'(1);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            cause_reg <= '0;
        end else if (in_rst_next && (state_next != state_reg || soft_req)) begin
            cause_reg <= cause_next;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_rst_b_reg    <= 1'b0;
            host_if_rst_b_reg <= 1'b0;
        end else begin
            core_rst_b_reg    <= ~in_rst_next;
            host_if_rst_b_reg <= ~hif_rst_next;
        end
    end

    // pin reset is not a power switch: during any reset regulators follow the enable pin and fw_reg_off is ignored
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            core_reg_en_reg  <= '0;
            low_power_en_reg <= 1'b0;
        end else begin
            core_reg_en_reg  <= {NUM_REG{regulator_enable_pin_s2_reg}} &
                                ~(in_rst_next ? '0 : fw_reg_off);
            low_power_en_reg <= fw_low_power_req && state_next == ST_RUN;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            boot_clk_int_reg <= 1'b1;
            xtal_freq_reg    <= '0;
        end else begin
            boot_clk_int_reg <= state_next != ST_RUN;
            if (fw_xtal_cfg_wr && !in_rst_next) begin
                xtal_freq_reg <= fw_xtal_freq;
            end
        end
    end

    // illegal mode codes are ignored rather than half-applied
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            host_mode_reg <= HM_SD1;
        end else if (hif_rst_next) begin
            host_mode_reg <= HM_SD1;
        end else if (host_mode_wr &&
                     host_mode_sel inside {HM_SD1, HM_SD4, HM_SPI}) begin
            host_mode_reg <= host_mode_sel;
        end
    end

    // pad states during reset
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            dpad_oe_b_reg    <= '1;
            dpad_pull_dn_reg <= '1;
            pull_up_reg      <= 1'b1;
        end else begin
            dpad_oe_b_reg    <= in_rst_next ? '1 : dpad_oe_b_req;
            dpad_pull_dn_reg <= in_rst_next ? '1 : dpad_pd_req;
            pull_up_reg      <= 1'b1;
        end
    end

    for (genvar i = 0; i < NUM_PIO; i++) begin : g_pio
        logic dir_reg;
        logic out_reg;
        logic pd_reg;
        logic pu_reg;
        logic in_s1_reg;
        logic in_s2_reg;

        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                dir_reg <= 1'b0;
                out_reg <= 1'b0;
                pd_reg  <= 1'b1;
                pu_reg  <= 1'b0;
            end else if (in_rst_next) begin
                dir_reg <= 1'b0;
                out_reg <= 1'b0;
                pd_reg  <= 1'b1;
                pu_reg  <= 1'b0;
            end else if (pio_cfg_wr) begin
                dir_reg <= pio_cfg_dir[i];
                out_reg <= pio_cfg_out[i];
                pd_reg  <= pio_cfg_pd[i];
                pu_reg  <= pio_cfg_pu[i];
            end
        end

        always_ff @(posedge sys_clk or negedge rst_b) begin
            if (!rst_b) begin
                in_s1_reg <= 1'b0;
                in_s2_reg <= 1'b0;
            end else begin
                in_s1_reg <= programmable_io_line_in[i];
                in_s2_reg <= in_s1_reg;
            end
        end

        assign programmable_io_line_out[i]     = out_reg;
        assign programmable_io_line_oe_b[i]    = ~dir_reg;
        assign programmable_io_line_pull_dn[i] = pd_reg;
        assign programmable_io_line_pull_up[i] = pu_reg;
        assign programmable_io_line_val[i]     = in_s2_reg;
    end

    // checker helper: cycles the synchronised pin has stayed low
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_low_cyc_reg <= '0;
        end else if (!pin_low_s) begin
            pin_low_cyc_reg <= '0;
        end else if (pin_low_cyc_reg != PIN_MAX_W) begin
            pin_low_cyc_reg <= pin_low_cyc_reg + PCW'(1);
        end
    end

    assign core_rst_b        = core_rst_b_reg;
    assign host_if_rst_b     = host_if_rst_b_reg;
    assign por_active        = por_reg;
    assign core_reg_en       = core_reg_en_reg;
    assign low_power_en      = low_power_en_reg;
    assign boot_clk_int      = boot_clk_int_reg;
    assign xtal_freq         = xtal_freq_reg;
    assign host_mode         = host_mode_reg;
    assign reset_cause       = cause_reg;
    assign dpad_oe_b         = dpad_oe_b_reg;
    assign dpad_pull_dn      = dpad_pull_dn_reg;
    assign reset_pad_pull_up = pull_up_reg;
    assign dbg_cs_pull_up    = pull_up_reg;
    // always-on domain does not follow the regulator enable
    assign aon_domain_en     = 1'b1;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    a_por_entry: assert property (!core_pwr_s |=> por_reg ##1 (state_reg == ST_POR && !core_rst_b))
        else $error("core power loss did not give power-on reset");
    a_por_hold: assert property (por_reg && core_supply_mv <= `MRPC_POR_RELEASE_MV |=> por_reg)
        else $error("power-on reset released below upper threshold");
    a_por_stay_off: assert property (!por_reg && core_pwr_s && core_supply_mv >= `MRPC_POR_ASSERT_MV |=> !por_reg)
        else $error("power-on reset above lower threshold");
    a_pin_late: assert property (pin_low_cyc_reg == PIN_MAX_W |-> pin_filt)
        else $error("pin reset later than maximum");
    a_pin_early: assert property ($rose(pin_filt) |-> pin_low_cyc_reg >= PIN_MIN_W)
        else $error("pin reset earlier than minimum");
    a_host_if_keep: assert property (state_reg == ST_SOFT |-> host_if_rst_b && !core_rst_b)
        else $error("soft reset touched host interface");
    a_host_if_pin: assert property (state_reg == ST_PIN |-> !host_if_rst_b)
        else $error("pin reset missed host interface");
    a_pads_reset: assert property (!core_rst_b |-> (&dpad_oe_b) && (&dpad_pull_dn) && reset_pad_pull_up && dbg_cs_pull_up)
        else $error("pads not in reset state");
    a_pio_default: assert property ($rose(core_rst_b) |-> (&programmable_io_line_oe_b) && (&programmable_io_line_pull_dn) && !(|programmable_io_line_pull_up))
        else $error("lines not input with pull-down after reset");
    a_regulator_enable_pin_off: assert property (!regulator_enable_pin_s2_reg |=> core_reg_en == '0)
        else $error("regulators on with enable low");
    a_fw_reg_off: assert property (regulator_enable_pin_s2_reg && state_reg == ST_RUN && state_next == ST_RUN |=> core_reg_en == ~$past(fw_reg_off))
        else $error("firmware regulator switch-off not applied");
    a_mode_hold: assert property (!host_mode_wr && !hif_rst_next |=> $stable(host_mode))
        else $error("host mode changed without cause");
    a_mode_default: assert property (state_reg inside {ST_POR, ST_PIN} |-> host_mode == HM_SD1)
        else $error("host mode not back to one-bit");
    a_boot_clk: assert property ($rose(core_rst_b) |-> boot_clk_int)
        else $error("crystal clock used before configuration");
    a_no_low_power: assert property (state_reg == ST_PIN |-> !low_power_en)
        else $error("pin reset entered low power");
    a_aon_alive: assert property (!regulator_enable_pin_s2_reg |-> aon_domain_en)
        else $error("always-on domain dropped");

endmodule : mrpc_top

// ---- bench/mrpc_board_model.sv ----
// board power and reset controller model
`timescale 1ns/1ns
module mrpc_board_model #(
    parameter int LF_HALF_NS = 160
) (
    input  wire logic        sys_clk,
    output logic             lf_clk_in,
    output logic             reset_pin_b_in,
    output logic             regulator_enable_pin,
    output logic             core_regulator_input_supply_ok,
    output logic [11:0]      core_supply_mv
);
    initial begin
        lf_clk_in = 1'b0;
        reset_pin_b_in = 1'b1;
        regulator_enable_pin = 1'b0;
        core_regulator_input_supply_ok = 1'b0;
        core_supply_mv = 12'h000;
    end
    // oscillator free-runs, unrelated in phase to sys_clk
    always #(LF_HALF_NS) lf_clk_in = ~lf_clk_in;
    // other rails assumed up already, core input comes last
    task automatic power_up();
        @(negedge sys_clk) regulator_enable_pin = 1'b1;
        @(negedge sys_clk) core_regulator_input_supply_ok = 1'b1;
        @(negedge sys_clk) core_supply_mv = 12'h4b0;
    endtask : power_up
    task automatic set_mv(input logic [11:0] mv);
        @(negedge sys_clk) core_supply_mv = mv;
    endtask : set_mv
    task automatic set_pin(input logic lvl);
        @(negedge sys_clk) reset_pin_b_in = lvl;
    endtask : set_pin
    task automatic regulator_enable_pin_pulse(input int n);
        @(negedge sys_clk) regulator_enable_pin = 1'b0;
        repeat (n) @(negedge sys_clk);
        regulator_enable_pin = 1'b1;
    endtask : regulator_enable_pin_pulse
endmodule : mrpc_board_model

// ---- bench/mrpc_top_tb_top.sv ----
// self-checking testbench for reset and power control
`timescale 1ns/1ns
module mrpc_top_tb_top;
    import mrpc_pkg::*;
    localparam int LF = 40;
    logic sys_clk, rst_b, wdog_rst_req, host_rst_req;
    logic lf_clk_in, reset_pin_b_in, regulator_enable_pin, core_regulator_input_supply_ok;
    logic [11:0] core_supply_mv;
    logic [3:0]  fw_reg_off;
    logic fw_low_power_req, fw_xtal_cfg_wr, host_mode_wr, pio_cfg_wr;
    logic [15:0] fw_xtal_freq;
    logic [2:0]  host_mode_sel;
    logic [5:0]  pio_cfg_dir, pio_cfg_pd, pio_cfg_out, pio_cfg_pu, pio_in;
    logic [7:0]  dpad_oe_b_req, dpad_pd_req;
    logic core_rst_b, host_if_rst_b, por_active, low_power_en, boot_clk_int;
    logic reset_pad_pull_up, dbg_cs_pull_up, aon_domain_en;
    logic [3:0]  core_reg_en, reset_cause;
    logic [15:0] xtal_freq;
    logic [2:0]  host_mode;
    logic [5:0]  pio_out, pio_oe_b, pio_pd, pio_pu, pio_val;
    logic [7:0]  dpad_oe_b, dpad_pull_dn;
    int error_cnt = 0, num_checks = 0, n;
    always #4 sys_clk = ~sys_clk;
    mrpc_board_model i_board (.sys_clk, .lf_clk_in, .reset_pin_b_in, .regulator_enable_pin,
        .core_regulator_input_supply_ok, .core_supply_mv);
    mrpc_top #(.PIN_TICKS(3), .PIN_MIN_CYC(2 * LF), .PIN_MAX_CYC(5 * LF + 8)) i_dut (
        .sys_clk, .rst_b, .reset_pin_b_in, .lf_clk_in, .regulator_enable_pin,
        .core_regulator_input_supply_ok, .core_supply_mv, .wdog_rst_req, .host_rst_req,
        .fw_reg_off, .fw_low_power_req, .fw_xtal_cfg_wr, .fw_xtal_freq, .host_mode_wr,
        .host_mode_sel, .pio_cfg_wr, .pio_cfg_dir, .pio_cfg_out, .pio_cfg_pd,
        .pio_cfg_pu, .programmable_io_line_in(pio_in), .dpad_oe_b_req,
        .dpad_pd_req, .core_rst_b, .host_if_rst_b, .por_active, .core_reg_en,
        .low_power_en, .boot_clk_int, .xtal_freq, .host_mode, .reset_cause,
        .programmable_io_line_out(pio_out), .programmable_io_line_oe_b(pio_oe_b),
        .programmable_io_line_pull_dn(pio_pd), .programmable_io_line_pull_up(pio_pu),
        .programmable_io_line_val(pio_val), .dpad_oe_b, .dpad_pull_dn, .reset_pad_pull_up,
        .dbg_cs_pull_up, .aon_domain_en);
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_of_test();
        if (error_cnt == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test
    // count negedges until core reset output reaches lvl
    task automatic wait_rst(input logic lvl, input int lim);
        n = 0;
        while (core_rst_b !== lvl) begin
            @(negedge sys_clk);
            n++;
            if (n > lim) begin
                chk("timeout", 1'b1, 1'b0);
                end_of_test();
            end
        end
    endtask : wait_rst
    task automatic pads_reset();
        chk("pio_oe_b", pio_oe_b, 6'h3f);
        chk("pio_pd", pio_pd, 6'h3f);
        chk("dpad_oe_b", dpad_oe_b, 8'hff);
        chk("pullups", {reset_pad_pull_up, dbg_cs_pull_up}, 2'b11);
        chk("pio_out_pu", {pio_out, pio_pu}, 12'h000);
        chk("dpad_pull_dn", dpad_pull_dn, 8'hff);
    endtask : pads_reset
    task automatic t_power_on();
        i_board.power_up();
        wait_rst(1'b1, 100);
        chk("por_active", por_active, 1'b0);
        chk("reset_cause", reset_cause, 4'h0);
        chk("host_mode", host_mode, 3'h1);
        chk("boot_clk", boot_clk_int, 1'b1);
        chk("core_reg_en", core_reg_en, 4'hf);
        pads_reset();
    endtask : t_power_on
    task automatic t_config();
        @(negedge sys_clk);
        {fw_reg_off, fw_low_power_req, fw_xtal_cfg_wr, fw_xtal_freq} = {4'h5, 1'b1, 1'b1, 16'h1234};
        {host_mode_wr, host_mode_sel, pio_cfg_wr, pio_cfg_dir, pio_cfg_pd} = {1'b1, 3'h2, 1'b1, 6'h3f, 6'h00};
        {dpad_oe_b_req, dpad_pd_req} = {8'h00, 8'h0f};
        {pio_cfg_out, pio_cfg_pu, pio_in} = {6'h2a, 6'h15, 6'h33};
        @(negedge sys_clk);
        {fw_xtal_cfg_wr, pio_cfg_wr, host_mode_sel} = {1'b0, 1'b0, 3'h3}; // illegal code ignored
        @(negedge sys_clk) host_mode_wr = 1'b0;
        repeat (4) @(negedge sys_clk);
        chk("core_reg_en", core_reg_en, 4'ha);
        chk("xtal", {boot_clk_int, xtal_freq}, 17'h01234);
        chk("host_mode", host_mode, 3'h2);
        chk("pio_oe_b", pio_oe_b, 6'h00);
        chk("pio_cfg", {pio_out, pio_pu, pio_val}, 18'h2a573);
        chk("dpad_cfg", {dpad_oe_b, dpad_pull_dn}, 16'h000f);
        chk("low_power", low_power_en, 1'b1);
    endtask : t_config
    task automatic t_soft(input logic src);
        @(negedge sys_clk) {host_rst_req, wdog_rst_req} = {src, ~src};
        @(negedge sys_clk) {host_rst_req, wdog_rst_req} = 2'b00;
        chk("core_rst_b", core_rst_b, 1'b0);
        chk("reset_cause", reset_cause, src ? 4'h8 : 4'h4);
        chk("host_if_rst_b", host_if_rst_b, 1'b1);
        pads_reset();
        wait_rst(1'b1, 40);
        chk("soft_len", n >= 14 && n <= 17, 1'b1);
        chk("host_mode", host_mode, 3'h2);
    endtask : t_soft
    task automatic t_pin();
        i_board.set_pin(1'b0);
        repeat (LF - 10) @(negedge sys_clk);
        i_board.set_pin(1'b1);
        repeat (LF) @(negedge sys_clk);
        chk("glitch", core_rst_b, 1'b1);
        i_board.set_pin(1'b0);
        wait_rst(1'b0, 400);
        chk("pin_delay", n >= 2 * LF && n <= 5 * LF + 12, 1'b1);
        chk("cause_lp", {reset_cause, low_power_en, host_if_rst_b}, 6'h08);
        chk("host_mode", host_mode, 3'h1);
        chk("core_reg_en", core_reg_en, 4'hf);
        repeat (3 * LF) @(negedge sys_clk);
        i_board.set_pin(1'b1);
        wait_rst(1'b1, 100);
    endtask : t_pin
    task automatic t_por();
        i_board.set_mv(12'h41a);
        repeat (4) @(negedge sys_clk);
        chk("por_at_1050", por_active, 1'b0);
        i_board.set_mv(12'h419);
        wait_rst(1'b0, 10);
        chk("por", {por_active, reset_cause, host_if_rst_b}, 6'h22);
        chk("aon", aon_domain_en, 1'b1);
        i_board.set_mv(12'h44c);
        repeat (6) @(negedge sys_clk);
        chk("por_at_1100", por_active, 1'b1);
        i_board.set_mv(12'h44d);
        wait_rst(1'b1, 20);
        i_board.regulator_enable_pin_pulse(4);
        wait_rst(1'b0, 10);
        chk("regulator_enable_pin_por", por_active, 1'b1);
        wait_rst(1'b1, 20);
    endtask : t_por
    initial begin
        sys_clk = 1'b0;
        {rst_b, wdog_rst_req, host_rst_req, fw_reg_off, fw_low_power_req} = '0;
        {fw_xtal_cfg_wr, host_mode_wr, pio_cfg_wr, fw_xtal_freq, pio_cfg_dir} = '0;
        {pio_cfg_out, pio_cfg_pu, pio_in, host_mode_sel, pio_cfg_pd} = {18'h0, 3'h1, 6'h3f};
        {dpad_oe_b_req, dpad_pd_req} = 16'hffff;
        repeat (12) @(negedge sys_clk);
        rst_b = 1'b1;
        t_power_on();
        t_config();
        t_soft(1'b0);
        t_soft(1'b1);
        t_pin();
        t_por();
        end_of_test();
    end
endmodule : mrpc_top_tb_top
